// *** verilog/acfg_pkg.sv ***
// Function
// RQ1: Primary bit 7 picks internal or external clock
// RQ2: Primary bit 6 inverts clock for sync only
// RQ3: Primary ratio is 14 bits over two registers
// RQ4: Secondary bit 7 picks internal or external clock
// RQ5: Secondary bit 6 inverts clock for sync only
// RQ6: Secondary ratio is 14 bits over two registers
// RQ7: All four sync registers reset to zero
// RQ8: Status bit 7 flags sync to clock ratio error
// RQ9: Status bit 4 flags unsupported converter ratio
// RQ10: Status bit 3 flags invalid modulator rate
// RQ11: Status bit 2 flags PDM clock failure
// RQ12: Status bit 1 flags audio clock stopped 1ms
// RQ13: Status bits 6, 5, 0 read zero
// RQ14: Status register read-only, resets to zero
// RQ15: Controller bit makes port drive clocks; code drives the bit clock only with internal clock selected
// RQ16: One sync period per N selected clock edges
package acfg_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] PRI_FSYNC_GEN_CONTROL = 8'h38;
	localparam logic [7:0] PRI_BCLK_RATIO_LOW = 8'h39;
	localparam logic [7:0] SEC_FSYNC_GEN_CONTROL = 8'h3A;
	localparam logic [7:0] SEC_BCLK_RATIO_LOW = 8'h3B;
	localparam logic [7:0] CLOCK_ERROR_STATUS_FIRST = 8'h3C;
	localparam logic [7:0] PORT_MODE_CONTROL = 8'h40;
	localparam logic [7:0] IRQ_STATUS = 8'h41;
	localparam logic [7:0] IRQ_MASK = 8'h42;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int INT_SEL_BIT = 7;
	localparam int INVERT_BIT = 6;
	localparam int RATIO_HIGH_MSB = 5;
	localparam int ST_RATIO_BIT = 7;
	localparam int ST_CONV_BIT = 4;
	localparam int ST_MOD_BIT = 3;
	localparam int ST_PDM_BIT = 2;
	localparam int ST_STOP_BIT = 1;
	localparam int PRI_CTRL_BIT = 0;
	localparam int SEC_CTRL_BIT = 1;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_HZ = 20000000;
	localparam int STOP_TIME_US = 1000;
	localparam int STOP_CYC = (CLK_FREQ_HZ / 1000000) * STOP_TIME_US;
	localparam int INT_BCLK_HALF = 4;

	typedef struct packed {
		logic int_sel;
		logic invert;
		logic [13:0] ratio;
	} acfg_fsgen_s;

	typedef enum logic [1:0] {
		FS_IDLE = 2'b00,
		FS_RUN = 2'b01
	} acfg_fs_e;

endpackage

// *** verilog/acfg_top.sv ***
`timescale 1ns/10ps
module acfg_top #(
	parameter int STOP_CYC = acfg_pkg::STOP_CYC,
	parameter int INT_BCLK_HALF = acfg_pkg::INT_BCLK_HALF
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] bclk_in,
	output logic [1:0] bclk_out,
	output logic [1:0] bclk_oe,
	input wire logic [1:0] fsync_in,
	output logic [1:0] fsync_out,
	output logic [1:0] fsync_oe,
	input wire logic converter_ratio_error,
	input wire logic src_custom_ratio,
	input wire logic modulator_rate_error,
	input wire logic pdm_clock_gen_error,
	output logic irq
);

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	logic [7:0] ctl_r [1:0];
	logic [7:0] low_r [1:0];
	logic [1:0] mode_r;
	logic [7:0] irq_st_r;
	logic [7:0] irq_mask_r;
	logic [7:0] status_r;
	logic [7:0] status_d_r;
	logic [7:0] reg_rdata_r;
	logic irq_r;
	logic [7:0] rd_mux;
	logic [1:0] wr_ctl;
	logic [1:0] wr_low;
	logic wr_mode;
	logic wr_iclr;
	logic wr_mask;
	logic [7:0] irq_ev;
	logic [7:0] irq_st_nxt;
	acfg_pkg::acfg_fsgen_s cfg [1:0];

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	assign wr_ctl[0] = reg_wr & hit(reg_addr, acfg_pkg::PRI_FSYNC_GEN_CONTROL);
	assign wr_ctl[1] = reg_wr & hit(reg_addr, acfg_pkg::SEC_FSYNC_GEN_CONTROL);
	assign wr_low[0] = reg_wr & hit(reg_addr, acfg_pkg::PRI_BCLK_RATIO_LOW);
	assign wr_low[1] = reg_wr & hit(reg_addr, acfg_pkg::SEC_BCLK_RATIO_LOW);
	assign wr_mode = reg_wr & hit(reg_addr, acfg_pkg::PORT_MODE_CONTROL);
	assign wr_iclr = reg_wr & hit(reg_addr, acfg_pkg::IRQ_STATUS);
	assign wr_mask = reg_wr & hit(reg_addr, acfg_pkg::IRQ_MASK);

	// Status register has no write decode at all
	assign rd_mux =
		hit(reg_addr, acfg_pkg::PRI_FSYNC_GEN_CONTROL) ? ctl_r[0] :
		hit(reg_addr, acfg_pkg::PRI_BCLK_RATIO_LOW) ? low_r[0] :
		hit(reg_addr, acfg_pkg::SEC_FSYNC_GEN_CONTROL) ? ctl_r[1] :
		hit(reg_addr, acfg_pkg::SEC_BCLK_RATIO_LOW) ? low_r[1] :
		hit(reg_addr, acfg_pkg::CLOCK_ERROR_STATUS_FIRST) ? status_r :
		hit(reg_addr, acfg_pkg::PORT_MODE_CONTROL) ? {6'h00, mode_r} :
		hit(reg_addr, acfg_pkg::IRQ_STATUS) ? irq_st_r :
		hit(reg_addr, acfg_pkg::IRQ_MASK) ? irq_mask_r :
		8'h00; // see RQ14

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctl_r[0] <= acfg_pkg::REG_RESET; // see RQ7
			ctl_r[1] <= acfg_pkg::REG_RESET; // see RQ7
			low_r[0] <= acfg_pkg::REG_RESET; // see RQ7
			low_r[1] <= acfg_pkg::REG_RESET; // see RQ7
			mode_r <= 2'h0;
			irq_mask_r <= acfg_pkg::REG_RESET;
		end else if (clk_en) begin
			if (wr_ctl[0])
				ctl_r[0] <= reg_wdata;
			if (wr_ctl[1])
				ctl_r[1] <= reg_wdata;
			if (wr_low[0])
				low_r[0] <= reg_wdata;
			if (wr_low[1])
				low_r[1] <= reg_wdata;
			if (wr_mode)
				mode_r <= reg_wdata[1:0];
			if (wr_mask)
				irq_mask_r <= reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reg_rdata_r <= 8'h00;
		end else if (clk_en) begin
			// Data stands only in the cycle after the read strobe
			reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
		end
	end

	assign reg_rdata = reg_rdata_r;

	// ----------------------------------------------------------------
	// Field unpacking
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cfg
			assign cfg[gi].int_sel = ctl_r[gi][acfg_pkg::INT_SEL_BIT];
			assign cfg[gi].invert = ctl_r[gi][acfg_pkg::INVERT_BIT];
			// High six bits in the control register, low byte after it
			assign cfg[gi].ratio =
				{ctl_r[gi][acfg_pkg::RATIO_HIGH_MSB:0], low_r[gi]}; // see RQ3 RQ6
		end
	endgenerate

	// ----------------------------------------------------------------
	// Internal bit clock divider
	// ----------------------------------------------------------------
	logic [15:0] div_cnt_r;
	logic int_bclk_r;
	logic div_wrap;

	assign div_wrap = (div_cnt_r == 16'(INT_BCLK_HALF - 1));

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			div_cnt_r <= 16'h0000;
			int_bclk_r <= 1'b0;
		end else if (clk_en) begin
			div_cnt_r <= div_wrap ? 16'h0000 : div_cnt_r + 16'h0001;
			if (div_wrap)
				int_bclk_r <= ~int_bclk_r;
		end
	end

	// ----------------------------------------------------------------
	// Per-port sync, frame sync generation and ratio check
	// ----------------------------------------------------------------
	logic [1:0] bclk_s1_r;
	logic [1:0] bclk_s2_r;
	logic [1:0] bclk_d_r;
	logic [1:0] fs_s1_r;
	logic [1:0] fs_s2_r;
	logic [1:0] fs_d_r;
	logic [1:0] ratio_err_r;
	logic [1:0] fsync_out_r;
	logic [1:0] bclk_out_r;
	logic [1:0] bclk_oe_r;
	logic [1:0] fsync_oe_r;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bclk_s1_r <= 2'h0;
			bclk_s2_r <= 2'h0;
			bclk_d_r <= 2'h0;
			fs_s1_r <= 2'h0;
			fs_s2_r <= 2'h0;
			fs_d_r <= 2'h0;
		end else if (clk_en) begin
			bclk_s1_r <= bclk_in;
			bclk_s2_r <= bclk_s1_r;
			bclk_d_r <= bclk_s2_r;
			fs_s1_r <= fsync_in;
			fs_s2_r <= fs_s1_r;
			fs_d_r <= fs_s2_r;
		end
	end

	generate
		for (gi = 0; gi < 2; gi++) begin : g_port
			acfg_pkg::acfg_fs_e state_r;
			acfg_pkg::acfg_fs_e state_nxt;
			logic [13:0] gen_cnt_r;
			logic [13:0] gen_cnt_nxt;
			logic [13:0] chk_cnt_r;
			logic [13:0] high_len;
			logic sel_clk;
			logic fs_clk;
			logic fs_clk_d_r;
			logic gen_edge;
			logic ext_edge;
			logic fs_rise;
			logic ctrl;
			logic chk_clear;
			logic [13:0] chk_cnt_nxt;

			assign ctrl = mode_r[gi]; // see RQ15
			// Inversion touches only this path, pins see the true clock
			assign sel_clk = cfg[gi].int_sel ? int_bclk_r
				: bclk_s2_r[gi]; // see RQ1 RQ4
			assign fs_clk = sel_clk ^ cfg[gi].invert; // see RQ2 RQ5
			assign gen_edge = fs_clk & ~fs_clk_d_r;
			assign ext_edge = bclk_s2_r[gi] & ~bclk_d_r[gi];
			assign fs_rise = fs_s2_r[gi] & ~fs_d_r[gi];
			assign state_nxt = (ctrl && cfg[gi].ratio != 14'h0000)
				? acfg_pkg::FS_RUN : acfg_pkg::FS_IDLE;
			assign gen_cnt_nxt = (gen_cnt_r >= cfg[gi].ratio - 14'h0001)
				? 14'h0000 : gen_cnt_r + 14'h0001; // see RQ16
			// Ratio of one holds the sync high on every edge instead of never raising it
			assign high_len = (cfg[gi].ratio < 14'h0002) ? 14'h0001
				: (cfg[gi].ratio >> 1);

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					state_r <= acfg_pkg::FS_IDLE;
					fs_clk_d_r <= 1'b0;
				end else if (clk_en) begin
					state_r <= state_nxt;
					fs_clk_d_r <= fs_clk;
				end
			end

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					gen_cnt_r <= 14'h0000;
					fsync_out_r[gi] <= 1'b0;
				end else if (clk_en) begin
					case (state_r)
						acfg_pkg::FS_IDLE: begin
							gen_cnt_r <= 14'h0000;
							fsync_out_r[gi] <= 1'b0;
						end
						acfg_pkg::FS_RUN: begin
							if (gen_edge) begin
								gen_cnt_r <= gen_cnt_nxt; // see RQ16
								fsync_out_r[gi] <= gen_cnt_nxt < high_len;
							end
						end
						default: begin
							gen_cnt_r <= 14'h0000;
							fsync_out_r[gi] <= 1'b0;
						end
					endcase
				end
			end

			// Target mode: count external edges per incoming frame
			// First frame after a ratio change is partial and may flag
			assign chk_clear = ctrl || (cfg[gi].ratio == 14'h0000);
			// Counter saturates so a stopped sync never wraps to a match
			assign chk_cnt_nxt = chk_clear ? 14'h0000
				: fs_rise ? {13'h0000, ext_edge}
				: (ext_edge && chk_cnt_r != 14'h3FFF)
				? chk_cnt_r + 14'h0001
				: chk_cnt_r;

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					chk_cnt_r <= 14'h0000;
				end else if (clk_en) begin
					chk_cnt_r <= chk_cnt_nxt;
				end
			end

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					ratio_err_r[gi] <= 1'b0;
				end else if (clk_en) begin
					if (chk_clear)
						ratio_err_r[gi] <= 1'b0;
					else if (fs_rise)
						ratio_err_r[gi] <= chk_cnt_r != cfg[gi].ratio; // see RQ8
				end
			end

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					bclk_out_r[gi] <= 1'b0;
					bclk_oe_r[gi] <= 1'b0;
					fsync_oe_r[gi] <= 1'b0;
				end else if (clk_en) begin
					bclk_out_r[gi] <= int_bclk_r;
					bclk_oe_r[gi] <= ctrl & cfg[gi].int_sel; // see RQ15
					fsync_oe_r[gi] <= ctrl; // see RQ15
				end
			end
		end
	endgenerate

	assign fsync_out = fsync_out_r;
	assign fsync_oe = fsync_oe_r;
	assign bclk_out = bclk_out_r;
	assign bclk_oe = bclk_oe_r;

	// ----------------------------------------------------------------
	// Audio clock stop detection
	// ----------------------------------------------------------------
	// The primary external bit clock is taken as the audio clock source
	logic [31:0] stop_cnt_r;
	logic [31:0] stop_cnt_nxt;
	logic stopped_r;
	logic pri_edge;
	logic stop_full;

	// Both edges count, so a clock parked high or low is caught alike
	assign pri_edge = bclk_s2_r[0] ^ bclk_d_r[0];
	assign stop_full = (stop_cnt_r >= 32'(STOP_CYC));
	assign stop_cnt_nxt = pri_edge ? 32'h00000000
		: stop_full ? stop_cnt_r
		: stop_cnt_r + 32'h00000001;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			stop_cnt_r <= 32'h00000000;
		end else if (clk_en) begin
			stop_cnt_r <= stop_cnt_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			stopped_r <= 1'b0;
		end else if (clk_en) begin
			if (pri_edge)
				stopped_r <= 1'b0;
			else if (stop_full)
				stopped_r <= 1'b1; // see RQ12
		end
	end

	// ----------------------------------------------------------------
	// Status and interrupts
	// ----------------------------------------------------------------
	logic [7:0] status_nxt;
	logic irq_nxt;

	assign status_nxt = {
		|ratio_err_r, // see RQ8
		2'b00, // see RQ13
		converter_ratio_error & ~src_custom_ratio, // see RQ9
		modulator_rate_error, // see RQ10
		pdm_clock_gen_error, // see RQ11
		stopped_r, // see RQ12
		1'b0 // see RQ13
	};

	assign irq_ev = status_r & ~status_d_r;
	// A new event beats a clear in the same cycle
	assign irq_st_nxt = (irq_st_r & ~(wr_iclr ? reg_wdata : 8'h00)) | irq_ev;

	// Level output lags the sticky bits by one cycle
	assign irq_nxt = |(irq_st_r & irq_mask_r);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			status_r <= acfg_pkg::REG_RESET; // see RQ14
			status_d_r <= acfg_pkg::REG_RESET;
		end else if (clk_en) begin
			status_r <= status_nxt;
			status_d_r <= status_r;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_st_r <= acfg_pkg::REG_RESET;
			irq_r <= 1'b0;
		end else if (clk_en) begin
			irq_st_r <= irq_st_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign irq = irq_r;

endmodule

// *** sim/acfg_monitor.sv ***
`timescale 1ns/10ps
module acfg_monitor #(
	parameter int STOP_CYC = 20000,
	parameter int INT_BCLK_HALF = 4
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] bclk_out,
	input wire logic [1:0] bclk_oe,
	input wire logic [1:0] fsync_out,
	input wire logic [1:0] fsync_oe,
	input wire logic converter_ratio_error,
	input wire logic src_custom_ratio,
	input wire logic modulator_rate_error,
	input wire logic pdm_clock_gen_error
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	wire mapped = reg_addr inside {[8'h38:8'h3C], [8'h40:8'h42]};
	wire [2:0] lvl = {converter_ratio_error & ~src_custom_ratio,
		modulator_rate_error, pdm_clock_gen_error};
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence rd_stat;
		reg_rd && reg_addr == acfg_pkg::CLOCK_ERROR_STATUS_FIRST;
	endsequence
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
	a_unmapped_zero: assert property (
		reg_rd && !mapped |=> reg_rdata == 8'h00) else $error("unmapped");
	a_reserved_zero: assert property (
		rd_stat |=> reg_rdata[6:5] == 2'h0 && !reg_rdata[0])
		else $error("reserved bits set");
	a_status_levels: assert property (
		rd_stat ##0 $stable(lvl) |=> reg_rdata[4:2] == $past(lvl))
		else $error("status levels wrong");
	a_pri_quiet: assert property (
		!fsync_oe[0] [*2] |-> !fsync_out[0]) else $error("pri sync");
	a_sec_quiet: assert property (
		!fsync_oe[1] [*2] |-> !fsync_out[1]) else $error("sec sync");
	a_bclk_drive: assert property (
		(bclk_oe & ~fsync_oe) == 2'h0) else $error("clock driven");
	a_bclk_half: assert property (
		bclk_oe[0] && $rose(bclk_out[0]) |-> bclk_out[0] [*4] ##1
		!bclk_out[0]) else $error("clock half period");
	a_oe_on_write: assert property (
		$changed(fsync_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
		else $error("mode changed alone");
endmodule
bind acfg_top acfg_monitor #(.STOP_CYC(STOP_CYC),
	.INT_BCLK_HALF(INT_BCLK_HALF)) mon_u (.clock(clock),
	.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk_out(bclk_out),
	.bclk_oe(bclk_oe), .fsync_out(fsync_out), .fsync_oe(fsync_oe),
	.converter_ratio_error(converter_ratio_error),
	.src_custom_ratio(src_custom_ratio),
	.modulator_rate_error(modulator_rate_error),
	.pdm_clock_gen_error(pdm_clock_gen_error));

// *** sim/acfg_host_model.sv ***
`timescale 1ns/10ps
module acfg_host_model #(
	parameter int N = 16
) (
	input wire logic run,
	output logic [1:0] bclk,
	output logic [1:0] fsync
);
	// ----------------------------------------------------------------
	// Host clock and sync, one sync per N rising edges
	// ----------------------------------------------------------------
	int cnt;
	initial begin
		bclk = 2'h0;
		fsync = 2'h0;
		cnt = 0;
		#37;
		forever begin
			if (run) begin
				bclk = 2'h3;
				cnt = (cnt + 1) % N;
				#200;
				bclk = 2'h0;
				// Sync moves on the falling edge, stable at rising
				fsync = (cnt == 0) ? 2'h3 : 2'h0;
				#200;
			end else begin
				// Clock stands still while stopped
				#50;
			end
		end
	end
endmodule

// *** sim/acfg_top_tb.sv ***
`timescale 1ns/10ps
module acfg_top_tb;
	logic clock, sys_rst, reg_wr, reg_rd, conv, cust, modr, pdm, run;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [1:0] bclk_out, bclk_oe, fsync_out, fsync_oe, hb, hf;
	wire [1:0] bclk_in = (bclk_oe & bclk_out) | (~bclk_oe & hb);
	wire [1:0] fsync_in = (fsync_oe & fsync_out) | (~fsync_oe & hf);
	wire irq;
	int n_errors = 0;
	int checks = 0;
	logic [7:0] pat [4] = '{8'hFF, 8'hA5, 8'h7E, 8'h5A};
	logic [7:0] cfg [4] = '{8'h00, 8'h10, 8'h00, 8'h10};
	acfg_top #(.STOP_CYC(50)) dut_u (.clock(clock), .sys_rst(sys_rst),
		.clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.bclk_in(bclk_in), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
		.fsync_in(fsync_in), .fsync_out(fsync_out), .fsync_oe(fsync_oe),
		.converter_ratio_error(conv), .src_custom_ratio(cust),
		.modulator_rate_error(modr), .pdm_clock_gen_error(pdm), .irq(irq));
	acfg_host_model host_u (.run(run), .bclk(hb), .fsync(hf));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, m, e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 check(16'(reg_rdata & m), 16'(e));
	endtask
	// Cycles between two rises of a generated sync
	task automatic meas(input int b, input logic [15:0] e);
		int t0;
		int k;
		logic p;
		t0 = -1;
		p = 1'b1;
		for (k = 0; k < 1000; k++) begin
			@(posedge clock);
			#1;
			if (fsync_out[b] && !p) begin
				if (t0 >= 0) break;
				t0 = k;
			end
			p = fsync_out[b];
		end
		check(16'(k - t0), e);
	endtask
	task automatic end_of_test;
		$display("Checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		end_of_test;
	end
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		{sys_rst, reg_wr, reg_rd, conv, cust, modr, pdm, run} = 8'h81;
		{reg_addr, reg_wdata} = 16'h0000;
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		for (int i = 0; i < 5; i++) rd(8'h38 + 8'(i), 8'hFF, 8'h00);
		rd(8'h50, 8'hFF, 8'h00);
		for (int i = 0; i < 4; i++) wr(8'h38 + 8'(i), pat[i]);
		for (int i = 0; i < 4; i++) rd(8'h38 + 8'(i), 8'hFF, pat[i]);
		for (int i = 0; i < 4; i++) wr(8'h38 + 8'(i), cfg[i]);
		wr(8'h3C, 8'h9E);
		repeat (300) @(posedge clock);
		rd(8'h3C, 8'hFF, 8'h00);
		{conv, modr, pdm} <= 3'h7;
		repeat (3) @(posedge clock);
		rd(8'h3C, 8'h1C, 8'h1C);
		cust <= 1'b1;
		repeat (3) @(posedge clock);
		rd(8'h3C, 8'h1C, 8'h0C);
		{conv, modr, pdm, cust} <= 4'h0;
		repeat (3) @(posedge clock);
		rd(8'h3C, 8'h1C, 8'h00);
		wr(8'h41, 8'hFF);
		wr(8'h39, 8'h11);
		repeat (300) @(posedge clock);
		rd(8'h3C, 8'h80, 8'h80);
		check(16'(irq), 16'h0000);
		rd(8'h41, 8'h80, 8'h80);
		wr(8'h42, 8'h80);
		repeat (2) @(posedge clock);
		check(16'(irq), 16'h0001);
		wr(8'h41, 8'h80);
		repeat (2) @(posedge clock);
		check(16'(irq), 16'h0000);
		wr(8'h39, 8'h10);
		repeat (300) @(posedge clock);
		rd(8'h3C, 8'h80, 8'h00);
		run <= 1'b0;
		repeat (30) @(posedge clock);
		rd(8'h3C, 8'h02, 8'h00);
		repeat (30) @(posedge clock);
		rd(8'h3C, 8'h02, 8'h02);
		run <= 1'b1;
		repeat (20) @(posedge clock);
		rd(8'h3C, 8'h02, 8'h00);
		wr(8'h40, 8'h01);
		wr(8'h38, 8'h40);
		repeat (5) @(posedge clock);
		check(16'({bclk_oe, fsync_oe}), 16'h0001);
		meas(0, 16'h0080);
		wr(8'h38, 8'h80);
		repeat (5) @(posedge clock);
		check(16'({bclk_oe, fsync_oe}), 16'h0005);
		meas(0, 16'h0080);
		wr(8'h3B, 8'h04);
		wr(8'h3A, 8'hC0);
		wr(8'h40, 8'h03);
		repeat (5) @(posedge clock);
		check(16'({bclk_oe, fsync_oe}), 16'h000F);
		meas(1, 16'h0020);
		wr(8'h3B, 8'h00);
		repeat (40) @(posedge clock);
		check(16'(fsync_out[1]), 16'h0000);
		end_of_test;
	end
endmodule
